// >>> hdl/p4g_regs.vh
// Register map, reset values and widths for the port 4 GPIO block
// Functional notes
// - All areas 8-bit wide means port works as general-purpose I/O.
// - Any 16-bit area hands pins to the external data bus, direction ignored.
// - In 8-bit mode direction bit 1 drives the pin, 0 makes it input.
// - Direction register is 8-bit and write-only, one bit per pin.
// - Direction clears on reset and hardware standby, holds in software standby.
// - Software standby reinitializes neither bus width config nor direction.
// - Output pins keep driving through software standby in GPIO mode.
// - 8-bit read/write output latch drives each output pin.
// - Port read gives latch for output pins, live pin level for inputs.
// - Output latch clears on reset and hardware standby, holds in software standby.
// - Pull-up on only in 8-bit mode, direction 0 and pull-up bit 1.
// - Pull-up control clears on reset and hardware standby, holds in software standby.
// - Pull-ups off in reset, hardware standby and always in 16-bit mode.
`ifndef P4G_REGS_VH
`define P4G_REGS_VH
// ****************************************************************
// Register offsets (low 20 address bits)
// ****************************************************************
`define P4G_ADDR_W        20
`define P4G_OFS_DIR       20'h0_ee003
`define P4G_OFS_PULLUP    20'h0_ee03e
`define P4G_OFS_LATCH     20'h0_fffd3
// ****************************************************************
// Reset values and widths
// ****************************************************************
`define P4G_DATA_W        8
`define P4G_RST_DIR       8'h00
`define P4G_RST_PULLUP    8'h00
`define P4G_RST_LATCH     8'h00
`define P4G_RD_NONE       8'h00
`define P4G_AREAS_8BIT    8'h00
`endif

// >>> hdl/p4g_pin_cell.v
// One port pin: drive, pull-up gating and read-back selection
`timescale 1ns/1ps
module p4g_pin_cell (
  input  wire dir_bit,
  input  wire latch_bit,
  input  wire pullup_bit,
  input  wire gpio_mode,
  input  wire pulls_blocked,
  input  wire bus_out,
  input  wire bus_oe,
  input  wire pin_in,
  output wire pin_out,
  output wire pin_oe,
  output wire pullup_on,
  output wire read_bit
);
  // Data bus owns the pad in 16-bit mode whatever direction holds
  assign pin_out   = gpio_mode ? latch_bit : bus_out;
  assign pin_oe    = gpio_mode ? dir_bit : bus_oe;
  assign pullup_on = gpio_mode & ~pulls_blocked & ~dir_bit & pullup_bit;
  assign read_bit  = dir_bit ? latch_bit : pin_in;
endmodule // p4g_pin_cell

// >>> hdl/p4g_port.v
// Port 4 GPIO with data-bus takeover in 16-bit bus mode
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "p4g_regs.vh"
module p4g_port #(
  parameter WIDTH = 8
) (
  input  wire                   ref_clk,
  input  wire                   nrst,
  input  wire                   hw_standby,
  input  wire                   sw_standby,
  input  wire [7:0]             area_bus_width_config,
  input  wire [`P4G_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr_stb,
  input  wire                   rd_stb,
  output reg  [7:0]             rdata,
  input  wire [WIDTH-1:0]       data_bus_out,
  input  wire                   data_bus_oe,
  input  wire [WIDTH-1:0]       pin_in,
  output wire [WIDTH-1:0]       pin_out,
  output wire [WIDTH-1:0]       pin_oe,
  output wire [WIDTH-1:0]       pullup_on,
  output wire                   gpio_mode
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [WIDTH-1:0] port_direction_r;
  reg  [WIDTH-1:0] port_output_latch_r;
  reg  [WIDTH-1:0] port_pullup_enable_r;
  wire [WIDTH-1:0] port_read;
  reg  [7:0]       rdata_nxt;

  function hit;
    input [`P4G_ADDR_W-1:0] a;
    input [`P4G_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Any set width bit means some area is 16-bit; no register stage
  assign gpio_mode = (area_bus_width_config == `P4G_AREAS_8BIT);

  // Hardware standby acts like reset; software standby leaves state alone
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_direction_r     <= `P4G_RST_DIR;
      port_output_latch_r  <= `P4G_RST_LATCH;
      port_pullup_enable_r <= `P4G_RST_PULLUP;
    end else if (hw_standby) begin
      port_direction_r     <= `P4G_RST_DIR;
      port_output_latch_r  <= `P4G_RST_LATCH;
      port_pullup_enable_r <= `P4G_RST_PULLUP;
    end else if (wr_stb) begin
      // Writes still land in software standby; nothing here clears state
      if (hit(addr, `P4G_OFS_DIR))
        port_direction_r <= wdata[WIDTH-1:0];
      if (hit(addr, `P4G_OFS_LATCH))
        port_output_latch_r <= wdata[WIDTH-1:0];
      if (hit(addr, `P4G_OFS_PULLUP))
        port_pullup_enable_r <= wdata[WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Direction register is write-only and reads as zero like unmapped space
  always @* begin
    rdata_nxt = `P4G_RD_NONE;
    if (hit(addr, `P4G_OFS_LATCH))
      rdata_nxt[WIDTH-1:0] = port_read;
    else if (hit(addr, `P4G_OFS_PULLUP))
      rdata_nxt[WIDTH-1:0] = port_pullup_enable_r;
    else if (hit(addr, `P4G_OFS_DIR))
      rdata_nxt = `P4G_RD_NONE;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `P4G_RD_NONE;
    end else if (rd_stb) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= `P4G_RD_NONE;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      p4g_pin_cell u_cell (
        .dir_bit       (port_direction_r[i]),
        .latch_bit     (port_output_latch_r[i]),
        .pullup_bit    (port_pullup_enable_r[i]),
        .gpio_mode     (gpio_mode),
        .pulls_blocked (hw_standby | ~nrst),
        .bus_out       (data_bus_out[i]),
        .bus_oe        (data_bus_oe),
        .pin_in        (pin_in[i]),
        .pin_out       (pin_out[i]),
        .pin_oe        (pin_oe[i]),
        .pullup_on     (pullup_on[i]),
        .read_bit      (port_read[i])
      );
    end
  endgenerate
endmodule // p4g_port

// >>> testbench/p4g_port_monitor.sv
// Assertion checker for the port 4 GPIO block
`timescale 1ns/1ps
`include "p4g_regs.vh"
module p4g_mon (
  input logic        ref_clk, nrst, hw_standby, wr_stb, rd_stb, data_bus_oe, gpio_mode,
  input logic [7:0]  area_bus_width_config, wdata, rdata, pin_in, pin_out, pin_oe, pullup_on,
  input logic [19:0] addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_lat_wr; wr_stb && addr == `P4G_OFS_LATCH && !hw_standby; endsequence
  sequence s_port_rd; rd_stb && addr == `P4G_OFS_LATCH && gpio_mode; endsequence
  AST_MODE: assert property (gpio_mode == (area_bus_width_config == 8'h00)) else $error("mode");
  AST_BUS_OE: assert property (!gpio_mode |-> pin_oe == {8{data_bus_oe}}) else $error("bus oe");
  AST_PU_OFF: assert property (!gpio_mode || hw_standby |-> pullup_on == 8'h00) else $error("pu");
  AST_PU_IN: assert property ((pullup_on & pin_oe) == 8'h00) else $error("pu on output");
  AST_HWS: assert property (hw_standby ##1 gpio_mode |-> pin_oe == 8'h00) else $error("hws");
  AST_LAT: assert property (s_lat_wr ##1 gpio_mode |-> ((pin_out ^ $past(wdata)) & pin_oe) == 8'h00)
    else $error("latch out");
  AST_PORT_RD: assert property (s_port_rd |=> ((rdata ^ $past(pin_in)) & ~$past(pin_oe)) == 8'h00)
    else $error("port read");
  AST_DIR_RD: assert property (rd_stb && addr == `P4G_OFS_DIR |=> rdata == 8'h00) else $error("dir");
  AST_IDLE: assert property (!rd_stb |=> rdata == 8'h00) else $error("idle rdata");
endmodule // p4g_mon
bind p4g_port p4g_mon u_mon (.*);

// >>> testbench/p4g_pads.sv
// Pad model: outside drivers, pull-ups and floating lines
`timescale 1ns/1ps
module p4g_pads (
  input  logic       ref_clk,
  input  logic [7:0] pin_out, pin_oe, pullup_on, ext_val, ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] float_r = 8'h5a;
  // A released line wanders so a stale value never matches by luck
  always @(posedge ref_clk) float_r <= ~float_r;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_on | float_r));
endmodule // p4g_pads

// >>> testbench/p4g_port_test.sv
// Self-checking bench for the port 4 GPIO block
`timescale 1ns/1ps
`include "p4g_regs.vh"
module p4g_port_test;
  logic ref_clk = 0, nrst = 0, hw_standby = 0, sw_standby = 0, wr_stb = 0, rd_stb = 0;
  logic data_bus_oe = 0, gpio_mode;
  logic [7:0] area_bus_width_config = 8'h00, wdata = 8'h00, data_bus_out = 8'h00, rdata;
  logic [7:0] ext_val = 8'h00, ext_en = 8'hff, pin_in, pin_out, pin_oe, pullup_on, d, r1, r2, r3;
  logic [19:0] addr = 20'h0_0000;
  logic [31:0] seed = 32'h0000_b402;
  int mismatches = 0, compares = 0;
  always #5 ref_clk = ~ref_clk;
  p4g_port dut (.*);
  p4g_pads pads (.ref_clk, .pin_out, .pin_oe, .pullup_on, .ext_val, .ext_en, .pin_in);
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] port_rd(input logic [7:0] dir, lat, pin);
    return (lat & dir) | (pin & ~dir);
  endfunction
  task automatic chk(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] v);
    @(posedge ref_clk) {wr_stb, addr, wdata} <= {1'b1, a, v};
    @(posedge ref_clk) wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [7:0] v);
    @(posedge ref_clk) {rd_stb, addr} <= {1'b1, a};
    @(posedge ref_clk) rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic summarize;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`P4G_OFS_PULLUP, d); chk(d, `P4G_RST_PULLUP);
    rd(`P4G_OFS_DIR, d); chk(d, 8'h00);
    rd(20'h0_0000, d); chk(d, `P4G_RD_NONE);
    chk(pin_oe, `P4G_RST_DIR);
    $display("test reset done");
    repeat (20) begin
      r1 = rnd(); r2 = rnd(); r3 = rnd(); d = rnd();
      ext_val <= d;
      wr(`P4G_OFS_DIR, r1); wr(`P4G_OFS_LATCH, r2); wr(`P4G_OFS_PULLUP, r3);
      rd(`P4G_OFS_LATCH, d); chk(d, port_rd(r1, r2, ext_val));
      chk(pin_oe, r1);
      chk(pin_out & r1, r2 & r1);
      chk(pullup_on, r3 & ~r1);
      sw_standby <= 1'b1;
      rd(`P4G_OFS_PULLUP, d); chk(d, r3);
      chk(pin_oe, r1);
      sw_standby <= 1'b0;
    end
    $display("test gpio done");
    ext_en <= 8'h00;
    wr(`P4G_OFS_DIR, 8'h00); wr(`P4G_OFS_PULLUP, 8'hff);
    rd(`P4G_OFS_LATCH, d); chk(d, 8'hff);
    @(posedge ref_clk) {area_bus_width_config, data_bus_oe, data_bus_out} <= {8'h80, 1'b1, r2};
    @(posedge ref_clk) #1 chk(pullup_on, 8'h00);
    chk(pin_oe, 8'hff); chk({7'h00, gpio_mode}, 8'h00);
    chk(pin_out, r2);
    @(posedge ref_clk) {area_bus_width_config, hw_standby} <= {8'h00, 1'b1};
    @(posedge ref_clk) #1 chk(pullup_on, 8'h00);
    @(posedge ref_clk) hw_standby <= 1'b0;
    rd(`P4G_OFS_PULLUP, d); chk(d, 8'h00);
    wr(`P4G_OFS_DIR, 8'hff); rd(`P4G_OFS_LATCH, d); chk(d, 8'h00);
    $display("test modes done");
    summarize;
  end
  initial begin
    #100000 mismatches++;
    summarize;
  end
endmodule // p4g_port_test
